// File: shared/boot_power_pkg.sv
// Constants and types for the boot strap and power state block
package boot_power_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] IDLE_LIMIT_OFS = 8'h04;
  localparam logic [7:0] SLEEP_LIMIT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS     = 8'h0C;

  // Control register fields
  localparam int CTRL_SINK_ROLE_BIT  = 0;
  localparam int CTRL_MSTBY_BIT      = 1;
  localparam int CTRL_AUTO_SLEEP_BIT = 2;
  localparam logic [2:0] CTRL_RESET  = 3'h4;

  // Status register field positions
  localparam int STAT_BOOT_POS  = 0;
  localparam int STAT_POWER_POS = 4;
  localparam int STAT_IDX_POS   = 8;
  localparam int STAT_DB_POS    = 12;
  localparam int STAT_CFG_POS   = 16;

  // Reset values and cycle counts
  localparam logic [31:0] IDLE_LIMIT_RESET  = 32'h0001_0000;
  localparam logic [31:0] SLEEP_LIMIT_RESET = 32'h0010_0000;
  localparam logic [31:0] STRAP_SETTLE_CYCLES = 32'h0000_0004;

  // Boot EEPROM slave address and host slave address upper bits
  localparam logic [6:0] EEPROM_ADDR       = 7'h50;
  localparam logic [4:0] HOST_ADDR_UPPER   = 5'h08;

  // Dead-battery behaviour chosen by the straps
  typedef enum logic [1:0] {
    DB_SINK_OFF       = 2'b00,
    DB_SINK_ALWAYS_ON = 2'b01,
    DB_HIGH_VOLTAGE   = 2'b10
  } db_e;

  // Boot sequencer states
  typedef enum logic [2:0] {
    BOOT_SETTLE    = 3'b000,
    BOOT_PROBE     = 3'b001,
    BOOT_WAIT_EE   = 3'b010,
    BOOT_LOADING   = 3'b011,
    BOOT_WAIT_HOST = 3'b100,
    BOOT_DONE      = 3'b101
  } boot_e;

  // Power states; modern standby is an idle variant
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_IDLE   = 2'b01,
    PWR_MSTBY  = 2'b10,
    PWR_SLEEP  = 2'b11
  } power_e;

  // CC1 termination codes
  localparam logic [1:0] TERM_OPEN = 2'h0;
  localparam logic [1:0] TERM_RD   = 2'h1;
  localparam logic [1:0] TERM_RP3A = 2'h2;

  // Power path and mode outputs
  typedef struct packed {
    logic       source_5v;
    logic       sink_hv;
    logic       sink_ext;
    logic       cable;
    logic [1:0] cc1_term;
    logic       app_mode;
    logic       pd_phy;
  } paths_s;

endpackage

// File: hw/boot_strap_and_power_state.sv
// Strap decoder, configuration-load sequencer and power state manager
//
// Behaviour
// (R01) Straps are sampled once at boot and fix address index and dead-battery setting before loading.
// (R02) After sampling, a configuration read is attempted from the EEPROM at 7-bit address 0x50.
// (R03) With no EEPROM answer the block waits until a host loads configuration on the slave port.
// (R04) Each controller has its own EEPROM; it is never shared among controllers.
// (R05) Pairs (7,5),(5,5),(2,0),(1,7) give indices 1-4 and sink-always-on, PD off until loaded.
// (R06) Pairs (7,3),(3,3),(4,0),(3,7) give indices 1-4 and high-voltage negotiate with PD PHY on.
// (R07) The system does not pick high-voltage negotiate when the patch comes from EEPROM.
// (R08) Pairs (7,0),(0,0),(6,0),(5,7) give indices 1-4 and sink-off, PD off until loaded.
// (R09) The block is in exactly one of Active, Idle or Sleep and moves between them itself.
// (R10) In Sleep a new CC connection is still detected and wakes the block.
// (R11) Active goes to Idle only after a programmed interval free of all activity events.
// (R12) Active/Idle source enables the 5 V path, sink the sink path; cable supply on in all four.
// (R13) Modern standby and Sleep disable sink and cable paths, CC open; 5 V only in standby source.
// (R14) Host slave address is 01000 followed by index minus one, used once boot completes.
// (R15) Unlisted strap pairs act as sink-off with address index 1.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module boot_strap_and_power_state (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Strap and connection pins
  input  wire logic [2:0]             strap_input_one,
  input  wire logic [2:0]             strap_input_two,
  input  wire logic                   cc_attached,
  // Boot master port engine
  output logic                        eeprom_probe_req,
  output logic      [6:0]             eeprom_addr,
  input  wire logic                   eeprom_probe_done,
  input  wire logic                   eeprom_ack,
  input  wire logic                   eeprom_load_done,
  // Host slave port engine
  input  wire logic                   host_load_done,
  output logic      [6:0]             host_slave_addr,
  output logic                        host_addr_valid,
  // Activity events
  input  wire logic                   pd_msg_event,
  input  wire logic                   cc_change_event,
  input  wire logic                   gpio_event,
  input  wire logic                   i2c_event,
  input  wire logic                   voltage_alert,
  input  wire logic                   fault_alert,
  // Power paths and modes
  output boot_power_pkg::paths_s      paths,
  output boot_power_pkg::power_e      power_state,
  output logic                        config_loaded
);

  // Whole block state
  typedef struct packed {
    logic [6:0]             sync1;
    logic [6:0]             sync2;
    logic                   attach_prev;
    boot_power_pkg::boot_e  boot;
    boot_power_pkg::power_e power;
    logic [1:0]             idx;
    boot_power_pkg::db_e    db;
    logic                   cfg;
    logic                   probe;
    logic [2:0]             ctrl;
    logic [31:0]            idle_limit;
    logic [31:0]            sleep_limit;
    logic [31:0]            cnt;
    boot_power_pkg::paths_s out;
    logic [31:0]            rdata;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // Strap pair to {setting, index}; unlisted pairs fall back to sink-off #1
  function automatic logic [3:0] decode_strap(input logic [5:0] p);
    logic [3:0] r;
    r = {boot_power_pkg::DB_SINK_OFF, 2'h0}; // [R15]
    unique case (p)
      6'o75: r = {boot_power_pkg::DB_SINK_ALWAYS_ON, 2'h0}; // [R05]
      6'o55: r = {boot_power_pkg::DB_SINK_ALWAYS_ON, 2'h1};
      6'o20: r = {boot_power_pkg::DB_SINK_ALWAYS_ON, 2'h2};
      6'o17: r = {boot_power_pkg::DB_SINK_ALWAYS_ON, 2'h3};
      6'o73: r = {boot_power_pkg::DB_HIGH_VOLTAGE, 2'h0}; // [R06]
      6'o33: r = {boot_power_pkg::DB_HIGH_VOLTAGE, 2'h1};
      6'o40: r = {boot_power_pkg::DB_HIGH_VOLTAGE, 2'h2};
      6'o37: r = {boot_power_pkg::DB_HIGH_VOLTAGE, 2'h3};
      6'o70: r = {boot_power_pkg::DB_SINK_OFF, 2'h0}; // [R08]
      6'o00: r = {boot_power_pkg::DB_SINK_OFF, 2'h1};
      6'o60: r = {boot_power_pkg::DB_SINK_OFF, 2'h2};
      6'o57: r = {boot_power_pkg::DB_SINK_OFF, 2'h3};
      default: r = {boot_power_pkg::DB_SINK_OFF, 2'h0}; // [R15]
    endcase
    return r;
  endfunction

  logic       activity;
  logic       attach_now;
  logic       wake;
  logic       setup;
  logic       mapped;
  logic [3:0] dec;

  // Activity, wake and bus decode
  assign activity   = pd_msg_event | cc_change_event | gpio_event | i2c_event
                    | voltage_alert | fault_alert;
  assign attach_now = st_reg.sync2[6];
  assign wake       = attach_now & ~st_reg.attach_prev;
  assign setup      = psel & ~penable;
  assign mapped     = (paddr == boot_power_pkg::CTRL_OFS) ||
                      (paddr == boot_power_pkg::IDLE_LIMIT_OFS) ||
                      (paddr == boot_power_pkg::SLEEP_LIMIT_OFS) ||
                      (paddr == boot_power_pkg::STATUS_OFS);
  assign dec        = decode_strap(st_reg.sync2[5:0]);

  // Next state of the whole block
  always_comb begin
    st_next             = st_reg;
    st_next.sync1       = {cc_attached, strap_input_one, strap_input_two};
    st_next.sync2       = st_reg.sync1;
    st_next.attach_prev = attach_now;
    st_next.probe       = 1'b0;

    // Boot sequencer
    unique case (st_reg.boot)
      boot_power_pkg::BOOT_SETTLE: begin
        st_next.cnt = st_reg.cnt + 32'h0000_0001;
        if (st_reg.cnt >= boot_power_pkg::STRAP_SETTLE_CYCLES) begin
          st_next.idx   = dec[1:0]; // [R01]
          st_next.db    = boot_power_pkg::db_e'(dec[3:2]);
          st_next.probe = 1'b1; // [R02]
          st_next.cnt   = 32'h0000_0000;
          st_next.boot  = boot_power_pkg::BOOT_PROBE;
        end
      end
      boot_power_pkg::BOOT_PROBE: begin
        st_next.boot = boot_power_pkg::BOOT_WAIT_EE;
      end
      boot_power_pkg::BOOT_WAIT_EE: begin
        if (eeprom_probe_done) begin
          st_next.boot = eeprom_ack ? boot_power_pkg::BOOT_LOADING
                                    : boot_power_pkg::BOOT_WAIT_HOST; // [R03]
        end
      end
      boot_power_pkg::BOOT_LOADING: begin
        if (eeprom_load_done) begin
          st_next.cfg  = 1'b1;
          st_next.boot = boot_power_pkg::BOOT_DONE;
        end
      end
      boot_power_pkg::BOOT_WAIT_HOST: begin
        if (host_load_done) begin
          st_next.cfg  = 1'b1; // [R03]
          st_next.boot = boot_power_pkg::BOOT_DONE;
        end
      end
      boot_power_pkg::BOOT_DONE: begin
        st_next.boot = boot_power_pkg::BOOT_DONE;
      end
      default: st_next.boot = boot_power_pkg::BOOT_SETTLE;
    endcase

    // Power state manager, running once boot completes
    if (st_reg.boot == boot_power_pkg::BOOT_DONE) begin
      unique case (st_reg.power)
        boot_power_pkg::PWR_ACTIVE: begin
          if (activity) begin
            st_next.cnt = 32'h0000_0000; // [R11]
          end else if (st_reg.cnt >= st_reg.idle_limit) begin
            st_next.cnt   = 32'h0000_0000;
            st_next.power = st_reg.ctrl[boot_power_pkg::CTRL_MSTBY_BIT]
                          ? boot_power_pkg::PWR_MSTBY : boot_power_pkg::PWR_IDLE; // [R11]
          end else begin
            st_next.cnt = st_reg.cnt + 32'h0000_0001;
          end
        end
        boot_power_pkg::PWR_IDLE, boot_power_pkg::PWR_MSTBY: begin
          if (activity || wake) begin
            st_next.cnt   = 32'h0000_0000;
            st_next.power = boot_power_pkg::PWR_ACTIVE; // [R09]
          end else if (st_reg.ctrl[boot_power_pkg::CTRL_AUTO_SLEEP_BIT] && !attach_now &&
                       st_reg.cnt >= st_reg.sleep_limit) begin
            st_next.cnt   = 32'h0000_0000;
            st_next.power = boot_power_pkg::PWR_SLEEP; // [R09]
          end else begin
            st_next.cnt = st_reg.cnt + 32'h0000_0001;
          end
        end
        boot_power_pkg::PWR_SLEEP: begin
          if (wake || activity) begin
            st_next.cnt   = 32'h0000_0000;
            st_next.power = boot_power_pkg::PWR_ACTIVE; // [R10]
          end
        end
      endcase
    end

    // Path and mode outputs
    st_next.out = '0;
    if (!st_next.cfg) begin
      // Dead-battery behaviour before configuration is loaded
      st_next.out.sink_hv  = (st_next.db != boot_power_pkg::DB_SINK_OFF); // [R05] [R08]
      st_next.out.sink_ext = (st_next.db != boot_power_pkg::DB_SINK_OFF);
      st_next.out.cc1_term = boot_power_pkg::TERM_RD;
      st_next.out.app_mode = (st_next.db == boot_power_pkg::DB_HIGH_VOLTAGE); // [R06]
      st_next.out.pd_phy   = (st_next.db == boot_power_pkg::DB_HIGH_VOLTAGE);
    end else begin
      st_next.out.app_mode = 1'b1;
      st_next.out.pd_phy   = 1'b1;
      unique case (st_next.power)
        boot_power_pkg::PWR_ACTIVE, boot_power_pkg::PWR_IDLE: begin
          st_next.out.cable = 1'b1; // [R12]
          if (st_reg.ctrl[boot_power_pkg::CTRL_SINK_ROLE_BIT]) begin
            st_next.out.sink_hv  = 1'b1;
            st_next.out.sink_ext = 1'b1;
            st_next.out.cc1_term = boot_power_pkg::TERM_RP3A;
          end else begin
            st_next.out.source_5v = 1'b1;
            st_next.out.cc1_term  = boot_power_pkg::TERM_RD;
          end
        end
        boot_power_pkg::PWR_MSTBY: begin
          st_next.out.source_5v = ~st_reg.ctrl[boot_power_pkg::CTRL_SINK_ROLE_BIT]; // [R13]
        end
        boot_power_pkg::PWR_SLEEP: begin
          st_next.out.source_5v = 1'b0; // [R13]
        end
      endcase
    end

    // APB register writes in the access phase
    if (psel && penable && pwrite) begin
      unique case (paddr)
        boot_power_pkg::CTRL_OFS:        st_next.ctrl        = pwdata[2:0];
        boot_power_pkg::IDLE_LIMIT_OFS:  st_next.idle_limit  = pwdata;
        boot_power_pkg::SLEEP_LIMIT_OFS: st_next.sleep_limit = pwdata;
        default: st_next.ctrl = st_reg.ctrl;
      endcase
    end

    // APB read data captured in the setup phase
    st_next.rdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      unique case (paddr)
        boot_power_pkg::CTRL_OFS:        st_next.rdata = {29'h0, st_reg.ctrl};
        boot_power_pkg::IDLE_LIMIT_OFS:  st_next.rdata = st_reg.idle_limit;
        boot_power_pkg::SLEEP_LIMIT_OFS: st_next.rdata = st_reg.sleep_limit;
        boot_power_pkg::STATUS_OFS: begin
          st_next.rdata[boot_power_pkg::STAT_BOOT_POS +: 3]  = st_reg.boot;
          st_next.rdata[boot_power_pkg::STAT_POWER_POS +: 2] = st_reg.power;
          st_next.rdata[boot_power_pkg::STAT_IDX_POS +: 2]   = st_reg.idx;
          st_next.rdata[boot_power_pkg::STAT_DB_POS +: 2]    = st_reg.db;
          st_next.rdata[boot_power_pkg::STAT_CFG_POS]        = st_reg.cfg;
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg             <= '0;
      st_reg.boot        <= boot_power_pkg::BOOT_SETTLE;
      st_reg.power       <= boot_power_pkg::PWR_ACTIVE;
      st_reg.ctrl        <= boot_power_pkg::CTRL_RESET;
      st_reg.idle_limit  <= boot_power_pkg::IDLE_LIMIT_RESET;
      st_reg.sleep_limit <= boot_power_pkg::SLEEP_LIMIT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign prdata           = st_reg.rdata;
  assign pready           = 1'b1;
  assign pslverr          = psel & penable & ~mapped;
  assign eeprom_probe_req = st_reg.probe;
  assign eeprom_addr      = boot_power_pkg::EEPROM_ADDR; // [R02]
  assign host_slave_addr  = {boot_power_pkg::HOST_ADDR_UPPER, st_reg.idx}; // [R14]
  assign host_addr_valid  = (st_reg.boot == boot_power_pkg::BOOT_DONE); // [R14]
  assign paths            = st_reg.out;
  assign power_state      = st_reg.power;
  assign config_loaded    = st_reg.cfg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Probe follows strap latch in the same step
  AST_PROBE_AFTER_STRAP: assert property ( // [R01]
    eeprom_probe_req |-> (st_reg.boot == boot_power_pkg::BOOT_PROBE) && !config_loaded)
    else $error("probe issued outside strap latch");

  AST_EEPROM_ADDR: assert property ( // [R02]
    eeprom_probe_req |-> eeprom_addr == 7'h50 ##1 st_reg.boot == boot_power_pkg::BOOT_WAIT_EE)
    else $error("eeprom probe address or sequence wrong");

  AST_WAIT_HOST: assert property ( // [R03]
    (st_reg.boot == boot_power_pkg::BOOT_WAIT_EE && eeprom_probe_done && !eeprom_ack)
    |=> (st_reg.boot == boot_power_pkg::BOOT_WAIT_HOST) && !config_loaded)
    else $error("no wait for host after missing eeprom");

  AST_SINK_OFF: assert property ( // [R08]
    (!config_loaded && st_reg.db == boot_power_pkg::DB_SINK_OFF
     && st_reg.boot != boot_power_pkg::BOOT_SETTLE)
    |=> !paths.sink_hv || config_loaded || $changed(st_reg.db))
    else $error("sink path enabled in sink-off setting");

  AST_HV_PHY: assert property ( // [R06]
    (!config_loaded && st_reg.db == boot_power_pkg::DB_HIGH_VOLTAGE) ##1 !config_loaded
    |-> paths.pd_phy && paths.app_mode && paths.sink_hv)
    else $error("high voltage setting without phy and sink");

  AST_IDLE_AFTER_QUIET: assert property ( // [R11]
    (power_state == boot_power_pkg::PWR_ACTIVE) ##1 (power_state != boot_power_pkg::PWR_ACTIVE)
    |-> $past(st_reg.cnt) >= $past(st_reg.idle_limit) && !$past(activity))
    else $error("left active before quiet interval");

  AST_SLEEP_WAKE: assert property ( // [R10]
    (power_state == boot_power_pkg::PWR_SLEEP && wake) |=> power_state == boot_power_pkg::PWR_ACTIVE)
    else $error("sleep did not wake on attach");

  AST_LOW_POWER_PATHS: assert property ( // [R13]
    (config_loaded && (power_state == boot_power_pkg::PWR_SLEEP ||
                       power_state == boot_power_pkg::PWR_MSTBY))
    |-> !paths.sink_hv && !paths.cable && paths.cc1_term == boot_power_pkg::TERM_OPEN)
    else $error("low power state left paths on");

  AST_ACTIVE_PATHS: assert property ( // [R12]
    (config_loaded && $stable(power_state) && power_state == boot_power_pkg::PWR_ACTIVE)
    |-> paths.cable && (paths.source_5v != paths.sink_hv))
    else $error("active state paths wrong");

  AST_HOST_ADDR: assert property ( // [R14]
    host_addr_valid |-> config_loaded && host_slave_addr[6:2] == 5'b01000
                        && host_slave_addr[1:0] == st_reg.idx && $stable(host_slave_addr))
    else $error("host slave address wrong");

endmodule

// File: tb/boot_link_partner.sv
// Boot master engine and host loader model facing the boot sequencer
`timescale 1ns/1ps
module boot_link_partner (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Sequencer side
  input  wire logic       probe_req,
  input  wire logic [6:0] addr,
  output logic            probe_done,
  output logic            ack,
  output logic            load_done,
  output logic            host_done,
  // Bench controls
  input  wire logic       present,
  input  wire logic [2:0] delay
);
  logic [1:0] phase;
  logic [4:0] cnt;
  logic       answers;

  // Only a dedicated EEPROM at the fixed address answers
  assign answers = present && (addr == 7'h50);

  // Probe answer after a delay, then EEPROM load or host load
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 2'h0;
      cnt <= 5'h00;
      probe_done <= 1'b0;
      ack <= 1'b1;
      load_done <= 1'b0;
      host_done <= 1'b0;
    end else begin
      probe_done <= (phase == 2'h1) && (cnt == 5'h00);
      ack <= ((phase == 2'h1) && (cnt == 5'h00)) ? answers : ~ack; // Toggles outside answer
      load_done <= (phase == 2'h2) && (cnt == 5'h00) && answers;
      host_done <= (phase == 2'h2) && (cnt == 5'h00) && !answers;
      if (phase == 2'h0 && probe_req) begin
        phase <= 2'h1;
        cnt <= {2'h0, delay};
      end else if (phase != 2'h0 && phase != 2'h3) begin
        cnt <= (cnt == 5'h00) ? 5'h1E : cnt - 5'h01;
        if (cnt == 5'h00) begin
          phase <= phase + 2'h1;
        end
      end
    end
  end
endmodule

// File: tb/boot_strap_and_power_state_bench.sv
// Self-checking bench for the boot strap and power state block
`timescale 1ns/1ps
module boot_strap_and_power_state_bench;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  strap_input_one = 3'h0;
  logic [2:0]  strap_input_two = 3'h0;
  logic        cc_attached = 1'b0;
  logic        probe_req;
  logic        probe_done;
  logic        ack;
  logic        load_done;
  logic        host_done;
  logic [6:0]  ee_addr;
  logic [6:0]  host_addr;
  logic        addr_valid;
  logic        cfg;
  logic [5:0]  ev = 6'h00;
  logic        present = 1'b0;
  logic [2:0]  delay = 3'h0;
  logic [32:0] expq[$];
  int          err_count = 0;
  int          check_count = 0;
  int          seed = 32'h6386EDD9;
  int          n;
  logic [31:0] r;
  boot_power_pkg::paths_s paths;
  boot_power_pkg::power_e pstate;
  // Strap one, strap two, index minus one, setting
  logic [9:0]  tbl [13] = '{10'h3D1, 10'h2D5, 10'h109, 10'h0FD, 10'h3B2, 10'h1B6, 10'h20A,
                            10'h1FE, 10'h380, 10'h004, 10'h308, 10'h2FC, 10'h090};

  // Clock at 125 MHz
  always #4 clk = ~clk;

  boot_strap_and_power_state dut_u (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_input_one(strap_input_one), .strap_input_two(strap_input_two),
    .cc_attached(cc_attached), .eeprom_probe_req(probe_req), .eeprom_addr(ee_addr),
    .eeprom_probe_done(probe_done), .eeprom_ack(ack), .eeprom_load_done(load_done),
    .host_load_done(host_done), .host_slave_addr(host_addr), .host_addr_valid(addr_valid),
    .pd_msg_event(ev[0]), .cc_change_event(ev[1]), .gpio_event(ev[2]), .i2c_event(ev[3]),
    .voltage_alert(ev[4]), .fault_alert(ev[5]), .paths(paths), .power_state(pstate),
    .config_loaded(cfg));

  boot_link_partner part_u (
    .clk(clk), .reset_n(reset_n), .probe_req(probe_req), .addr(ee_addr),
    .probe_done(probe_done), .ack(ack), .load_done(load_done), .host_done(host_done),
    .present(present), .delay(delay));

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; a read notes its expected error bit and data
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    if (!wr) expq.push_back({err, d});
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_pwr(input boot_power_pkg::power_e s, input int lim);
    n = 0;
    while (pstate !== s && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic pulse(input logic [5:0] e);
    ev <= e;
    @(posedge clk);
    ev <= 6'h00;
    repeat (2) @(posedge clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Read data compared against the oldest expectation
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
      chk({pslverr, prdata}, expq.pop_front());
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  // Strap table boots, then power state walk
  initial begin
    for (int i = 0; i < 13; i++) begin
      strap_input_one <= tbl[i][9:7];
      strap_input_two <= tbl[i][6:4];
      present <= (tbl[i][1:0] != 2'h2) && i[0];
      delay <= 3'($random(seed));
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      if (i == 0) begin
        chk(33'(pstate), 33'(boot_power_pkg::PWR_ACTIVE));
        chk(33'(host_addr), 33'h020);
      end
      n = 0;
      while (probe_req !== 1'b1 && n < 60) begin
        @(posedge clk);
        n++;
      end
      chk(33'(n < 60), 33'h1);
      chk(33'(ee_addr), 33'h050);
      strap_input_one <= 3'($random(seed)); // Late strap change must not matter
      strap_input_two <= 3'($random(seed));
      repeat (12) @(posedge clk);
      chk(33'({cfg, addr_valid}), 33'h0);
      chk(33'({paths.sink_hv, paths.pd_phy}), 33'({tbl[i][1:0] != 2'h0, tbl[i][1:0] == 2'h2}));
      n = 0;
      while (cfg !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      chk(33'(addr_valid), 33'h1);
      chk(33'(host_addr), 33'({5'h08, tbl[i][3:2]}));
      apb(1'b0, boot_power_pkg::STATUS_OFS,
          {15'h0, 1'b1, 2'h0, tbl[i][1:0], 2'h0, tbl[i][3:2], 8'h05}, 1'b0);
      // Register access after boot; second pass sees reset values again
      if (i < 2) begin
        apb(1'b0, boot_power_pkg::CTRL_OFS, 32'(boot_power_pkg::CTRL_RESET), 1'b0);
        apb(1'b0, boot_power_pkg::SLEEP_LIMIT_OFS, boot_power_pkg::SLEEP_LIMIT_RESET, 1'b0);
        apb(1'b0, boot_power_pkg::IDLE_LIMIT_OFS, boot_power_pkg::IDLE_LIMIT_RESET, 1'b0);
        apb(1'b0, 8'h10, 32'h0000_0000, 1'b1);
        r = 32'($random(seed));
        apb(1'b1, boot_power_pkg::IDLE_LIMIT_OFS, r, 1'b0);
        apb(1'b0, boot_power_pkg::IDLE_LIMIT_OFS, r, 1'b0);
      end
    end
    apb(1'b1, boot_power_pkg::IDLE_LIMIT_OFS, 32'h0000_000A, 1'b0);
    apb(1'b1, boot_power_pkg::CTRL_OFS, 32'h0000_0001, 1'b0);
    for (int e = 0; e < 6; e++) begin
      pulse(6'(1 << e));
      chk(33'(pstate), 33'(boot_power_pkg::PWR_ACTIVE));
      wait_pwr(boot_power_pkg::PWR_IDLE, 100);
      chk(33'(n >= 8 && n <= 14), 33'h1);
      chk(33'(paths[7:2]), 33'({4'h7, boot_power_pkg::TERM_RP3A}));
    end
    apb(1'b1, boot_power_pkg::CTRL_OFS, 32'h0000_0000, 1'b0);
    pulse(6'h01);
    chk(33'(paths[7:2]), 33'({4'h9, boot_power_pkg::TERM_RD}));
    apb(1'b1, boot_power_pkg::CTRL_OFS, 32'h0000_0002, 1'b0);
    wait_pwr(boot_power_pkg::PWR_MSTBY, 100);
    chk(33'(paths[7:2]), 33'({4'h8, boot_power_pkg::TERM_OPEN}));
    apb(1'b1, boot_power_pkg::CTRL_OFS, 32'h0000_0003, 1'b0);
    repeat (3) @(posedge clk);
    chk(33'(paths[7:2]), 33'h0);
    apb(1'b1, boot_power_pkg::SLEEP_LIMIT_OFS, 32'h0000_0014, 1'b0);
    apb(1'b1, boot_power_pkg::CTRL_OFS, 32'h0000_0005, 1'b0);
    pulse(6'h20);
    wait_pwr(boot_power_pkg::PWR_SLEEP, 400);
    chk(33'(pstate), 33'(boot_power_pkg::PWR_SLEEP));
    chk(33'(paths[7:2]), 33'h0);
    cc_attached <= 1'b1;
    wait_pwr(boot_power_pkg::PWR_ACTIVE, 8);
    chk(33'(pstate), 33'(boot_power_pkg::PWR_ACTIVE));
    wrap_up();
  end
endmodule
